// ### scmc_config_regs.sv
/*
  Supply and clock monitor configuration registers: monitor enables,
  supply trip and hot-warning selects, clock monitor enables and supply
  self-test enables, with one fault path per supply or ground monitor.
  Assumes the SPI frame decoder presents single-cycle read and write
  strobes with an 8-bit address and 16-bit data, on the system clock.
*/
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - IO over-trip select, reset 0: 0 picks 5.7 V, 1 picks 3.9 V.
// - IO under-trip select, reset 1: 0 picks 4.3 V, 1 picks 2.95 V.
// - Analog LDO hot warning bits 7:6, reset 11b: -60/100/120/140 C.
// - IO LDO hot warning bits 5:4, reset 11b, same four levels.
// - Threshold register bits 15:14, 11:8 and 3:0 read zero.
// - Clock config bits 9:3 read zero.
// - Clock config bit 2, reset 0, turns main clock frequency check on.
// - Clock config bit 1, reset 0, turns diagnostic osc watchdog on.
// - Clock config bit 0, reset 0, turns main clock watchdog on.
// - Diag bits 15:10 start supply over/under self-tests, reset 0.
// - Diag bits 9:7 start analog, IO, core ringing self-tests.
// - Passed self-test sets the active-low fault flag within the delay.
// - Diag register bits 6:3 read zero.
// - Each monitor has its own enable in a config register, reset clear.
// - Diag bits 2:0 start ground A, ground B, digital ground tests.
module scmc_config_regs #(
  parameter int unsigned PROP_CYC = scmc_pkg::DIAG_PROP_CYC,
  parameter int unsigned CNT_W    = 8
) (
  // Clock, reset, enable
  input  wire logic                           clk_sys_i,
  input  wire logic                           rst_b_i,
  input  wire logic                           ce_i,
  // Register access from the SPI frame decoder
  input  wire logic [scmc_pkg::ADDR_W-1:0]    reg_addr_i,
  input  wire logic [scmc_pkg::DATA_W-1:0]    reg_wdata_i,
  input  wire logic                           reg_wr_i,
  input  wire logic                           reg_rd_i,
  output logic      [scmc_pkg::DATA_W-1:0]    reg_rdata_o,
  output logic                                reg_rvalid_o,
  output logic                                reg_hit_o,
  // Supply thresholds
  output logic                                io_supply_over_trip_sel_o,
  output logic                                io_supply_under_trip_sel_o,
  output scmc_pkg::scmc_hot_e                 analog_ldo_hot_warn_level_o,
  output scmc_pkg::scmc_hot_e                 io_ldo_hot_warn_level_o,
  // Clock monitors
  output logic                                main_clk_freq_check_on_o,
  output logic                                diag_osc_watchdog_on_o,
  output logic                                main_clk_watchdog_on_o,
  // Other monitor enables
  output logic                                analog_hot_watch_on_o,
  output logic                                io_hot_watch_on_o,
  output logic                                analog_limit_on_o,
  output logic                                io_limit_on_o,
  // Per-channel monitors, bit 11 analog over down to bit 0 digital ground
  output logic      [scmc_pkg::NUM_CHAN-1:0]  chan_watch_on_o,
  input  wire logic [scmc_pkg::NUM_CHAN-1:0]  chan_raw_fault_i,
  output logic      [scmc_pkg::NUM_CHAN-1:0]  chan_force_fault_o,
  output logic      [scmc_pkg::NUM_CHAN-1:0]  chan_fault_flag_b_o
);

  localparam int unsigned NCH = scmc_pkg::NUM_CHAN;

  if (scmc_pkg::DATA_W != 16 || NCH != 12) begin : g_chk
    $error("scmc_config_regs: map needs 16-bit data and 12 channels");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] mon_cfg;
    logic [15:0] thr_cfg;
    logic [15:0] clk_cfg;
    logic [15:0] diag_cfg;
    logic [15:0] rdata;
    logic        rvalid;
    logic        hit;
  } scmc_regs_s;

  scmc_regs_s st_ff;
  scmc_regs_s nxt_st;

  logic        sel_mon;
  logic        sel_thr;
  logic        sel_clk;
  logic        sel_diag;
  logic [15:0] rd_mux;

  // ----------------------------------------------------------------
  // Address decode and read mux
  // ----------------------------------------------------------------
  always_comb begin
    sel_mon  = (reg_addr_i == scmc_pkg::ADDR_SUPPLY_MONITOR_CFG);
    sel_thr  = (reg_addr_i == scmc_pkg::ADDR_SUPPLY_THRESHOLD);
    sel_clk  = (reg_addr_i == scmc_pkg::ADDR_CLOCK_MONITOR_CFG);
    sel_diag = (reg_addr_i == scmc_pkg::ADDR_SUPPLY_DIAG_CFG);
    rd_mux   = 16'h0000;
    if (sel_mon) begin
      rd_mux = st_ff.mon_cfg;
    end
    if (sel_thr) begin
      // Reserved bits masked on read as well as write
      rd_mux = st_ff.thr_cfg & scmc_pkg::MASK_SUPPLY_THRESHOLD;
    end
    if (sel_clk) begin
      rd_mux = st_ff.clk_cfg & scmc_pkg::MASK_CLOCK_MONITOR_CFG;
    end
    if (sel_diag) begin
      rd_mux = st_ff.diag_cfg & scmc_pkg::MASK_SUPPLY_DIAG_CFG;
    end
  end

  // ----------------------------------------------------------------
  // Register update
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.rvalid = reg_rd_i;
    nxt_st.hit    = st_ff.hit;
    if (reg_rd_i) begin
      // Unmapped reads answer zero with hit low
      nxt_st.rdata = rd_mux;
      nxt_st.hit   = sel_mon | sel_thr | sel_clk | sel_diag;
    end
    if (reg_wr_i) begin
      if (sel_mon) begin
        nxt_st.mon_cfg = reg_wdata_i
                         & scmc_pkg::MASK_SUPPLY_MONITOR_CFG;
      end
      if (sel_thr) begin
        nxt_st.thr_cfg = reg_wdata_i
                         & scmc_pkg::MASK_SUPPLY_THRESHOLD;
      end
      if (sel_clk) begin
        // Reserved bits 9:3 are forced clear; bits 15:10 are kept as written
        nxt_st.clk_cfg = reg_wdata_i
                         & scmc_pkg::MASK_CLOCK_MONITOR_CFG;
      end
      if (sel_diag) begin
        nxt_st.diag_cfg = reg_wdata_i
                          & scmc_pkg::MASK_SUPPLY_DIAG_CFG;
      end
      if (!reg_rd_i) begin
        nxt_st.hit = sel_mon | sel_thr | sel_clk | sel_diag;
      end
    end
  end

  // Fields hold until rewritten or reset
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      st_ff <= '{mon_cfg:  scmc_pkg::RST_SUPPLY_MONITOR_CFG,
                 thr_cfg:  scmc_pkg::RST_SUPPLY_THRESHOLD,
                 clk_cfg:  scmc_pkg::RST_CLOCK_MONITOR_CFG,
                 diag_cfg: scmc_pkg::RST_SUPPLY_DIAG_CFG,
                 rdata:    16'h0000,
                 rvalid:   1'b0,
                 hit:      1'b0};
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Read answer
  // ----------------------------------------------------------------
  assign reg_rdata_o  = st_ff.rdata;
  assign reg_rvalid_o = st_ff.rvalid;
  assign reg_hit_o    = st_ff.hit;

  // ----------------------------------------------------------------
  // Threshold selects to the analog monitors
  // ----------------------------------------------------------------
  // 0 -> 5.7 V, 1 -> 3.9 V
  assign io_supply_over_trip_sel_o =
    st_ff.thr_cfg[scmc_pkg::POS_IO_OVER_TRIP];
  // 0 -> 4.3 V, 1 -> 2.95 V
  assign io_supply_under_trip_sel_o =
    st_ff.thr_cfg[scmc_pkg::POS_IO_UNDER_TRIP];
  assign analog_ldo_hot_warn_level_o = scmc_pkg::scmc_hot_e'(
    st_ff.thr_cfg[scmc_pkg::POS_ANALOG_HOT_LSB +: 2]);
  assign io_ldo_hot_warn_level_o = scmc_pkg::scmc_hot_e'(
    st_ff.thr_cfg[scmc_pkg::POS_IO_HOT_LSB +: 2]);

  // ----------------------------------------------------------------
  // Clock monitor enables
  // ----------------------------------------------------------------
  assign main_clk_freq_check_on_o =
    st_ff.clk_cfg[scmc_pkg::POS_MAIN_FREQ_ON];
  assign diag_osc_watchdog_on_o =
    st_ff.clk_cfg[scmc_pkg::POS_DIAG_OSC_WD_ON];
  assign main_clk_watchdog_on_o =
    st_ff.clk_cfg[scmc_pkg::POS_MAIN_WD_ON];

  // ----------------------------------------------------------------
  // Monitors with no self-test channel here
  // ----------------------------------------------------------------
  assign analog_hot_watch_on_o = st_ff.mon_cfg[scmc_pkg::POS_OTW_ANALOG_ON];
  assign io_hot_watch_on_o     = st_ff.mon_cfg[scmc_pkg::POS_OTW_IO_ON];
  assign analog_limit_on_o     = st_ff.mon_cfg[scmc_pkg::POS_CL_ANALOG_ON];
  assign io_limit_on_o         = st_ff.mon_cfg[scmc_pkg::POS_CL_IO_ON];

  // ----------------------------------------------------------------
  // Per-channel fault paths
  // ----------------------------------------------------------------
  logic [NCH-1:0] chan_on;
  logic [NCH-1:0] chan_test;

  // Enable and self-test bits share positions, so both gathers take the same bit ranges
  assign chan_on = {
    st_ff.mon_cfg[scmc_pkg::POS_SUPPLY_MSB:scmc_pkg::POS_SUPPLY_LSB],
    st_ff.mon_cfg[scmc_pkg::POS_GROUND_MSB:0]};
  assign chan_test = {
    st_ff.diag_cfg[scmc_pkg::POS_SUPPLY_MSB:scmc_pkg::POS_SUPPLY_LSB],
    st_ff.diag_cfg[scmc_pkg::POS_GROUND_MSB:0]};
  assign chan_watch_on_o = chan_on;

  for (genvar i = 0; i < NCH; i++) begin : g_chan
    scmc_fault_path #(
      .PROP_CYC (PROP_CYC),
      .CNT_W    (CNT_W)
    ) u_path (
      .clk_sys_i      (clk_sys_i),
      .rst_b_i        (rst_b_i),
      .ce_i           (ce_i),
      .mon_on_i       (chan_on[i]),
      .selftest_i     (chan_test[i]),
      .raw_fault_i    (chan_raw_fault_i[i]),
      .force_fault_o  (chan_force_fault_o[i]),
      .fault_flag_b_o (chan_fault_flag_b_o[i])
    );
  end

endmodule

`default_nettype wire

// ### scmc_pkg.sv
/*
  Constants for the supply and clock monitor configuration slice:
  register addresses, field positions, reset values, write masks and the
  self-test propagation timing.
  Assumes a 16-bit register map with 8-bit addresses behind the SPI
  frame decoder, and a 50 MHz system clock.
*/
package scmc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;

  localparam logic [7:0] ADDR_SUPPLY_MONITOR_CFG = 8'h41;
  localparam logic [7:0] ADDR_SUPPLY_THRESHOLD   = 8'h42;
  localparam logic [7:0] ADDR_CLOCK_MONITOR_CFG  = 8'h43;
  localparam logic [7:0] ADDR_SUPPLY_DIAG_CFG    = 8'h44;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_SUPPLY_MONITOR_CFG = 16'h0000;
  localparam logic [15:0] RST_SUPPLY_THRESHOLD   = 16'h10F0;
  localparam logic [15:0] RST_CLOCK_MONITOR_CFG  = 16'h0000;
  localparam logic [15:0] RST_SUPPLY_DIAG_CFG    = 16'h0000;

  // ----------------------------------------------------------------
  // Writable bits per register; all others read as zero
  // ----------------------------------------------------------------
  localparam logic [15:0] MASK_SUPPLY_MONITOR_CFG = 16'hFFFF;
  localparam logic [15:0] MASK_SUPPLY_THRESHOLD   = 16'h30F0;
  localparam logic [15:0] MASK_CLOCK_MONITOR_CFG  = 16'hFC07;
  localparam logic [15:0] MASK_SUPPLY_DIAG_CFG    = 16'hFF87;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned POS_IO_OVER_TRIP   = 13;
  localparam int unsigned POS_IO_UNDER_TRIP  = 12;
  localparam int unsigned POS_ANALOG_HOT_LSB = 6;
  localparam int unsigned POS_IO_HOT_LSB     = 4;
  localparam int unsigned POS_MAIN_FREQ_ON   = 2;
  localparam int unsigned POS_DIAG_OSC_WD_ON = 1;
  localparam int unsigned POS_MAIN_WD_ON     = 0;
  localparam int unsigned POS_OTW_ANALOG_ON  = 6;
  localparam int unsigned POS_OTW_IO_ON      = 5;
  localparam int unsigned POS_CL_ANALOG_ON   = 4;
  localparam int unsigned POS_CL_IO_ON       = 3;
  // Supply and ringing monitors sit in bits 15:7, grounds in 2:0
  localparam int unsigned POS_SUPPLY_MSB     = 15;
  localparam int unsigned POS_SUPPLY_LSB     = 7;
  localparam int unsigned POS_GROUND_MSB     = 2;
  localparam int unsigned NUM_CHAN           = 12;

  // ----------------------------------------------------------------
  // Hot-warning level codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SCMC_HOT_M60C,
    SCMC_HOT_100C,
    SCMC_HOT_120C,
    SCMC_HOT_140C
  } scmc_hot_e;

  // ----------------------------------------------------------------
  // Self-test propagation timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 20;
  localparam int unsigned DIAG_PROP_NS   = 1000;
  localparam int unsigned DIAG_PROP_CYC  =
    (DIAG_PROP_NS / CLK_PERIOD_NS < 1) ? 1 : DIAG_PROP_NS / CLK_PERIOD_NS;

endpackage

// ### scmc_fault_path.sv
/*
  One monitor channel: synchronises the raw comparator fault, forces the
  monitor into its fault state during self-test, and drives the active-low
  fault flag.
  Assumes the raw fault arrives asynchronously from the analog monitor.
*/
`timescale 1ns/100ps
`default_nettype none

module scmc_fault_path #(
  parameter int unsigned PROP_CYC = scmc_pkg::DIAG_PROP_CYC,
  parameter int unsigned CNT_W    = 8
) (
  // Clock, reset, enable
  input  wire logic clk_sys_i,
  input  wire logic rst_b_i,
  input  wire logic ce_i,
  // Configuration
  input  wire logic mon_on_i,
  input  wire logic selftest_i,
  // Analog side
  input  wire logic raw_fault_i,
  output logic      force_fault_o,
  // Flag
  output logic      fault_flag_b_o
);

  if (PROP_CYC < 1 || PROP_CYC >= (1 << CNT_W)) begin : g_chk
    $error("scmc_fault_path: PROP_CYC does not fit CNT_W");
  end

  localparam logic [CNT_W-1:0] PROP_LAST = CNT_W'(PROP_CYC - 1);

  typedef struct packed {
    logic             sync1;
    logic             sync2;
    logic [CNT_W-1:0] cnt;
    logic             done;
    logic             force_f;
    logic             flag_b;
  } scmc_fp_s;

  scmc_fp_s st_ff;
  scmc_fp_s nxt_st;
  logic     armed;

  always_comb begin
    nxt_st       = st_ff;
    nxt_st.sync1 = raw_fault_i;
    nxt_st.sync2 = st_ff.sync1;
    // Self-test only acts on an enabled monitor
    armed        = mon_on_i & selftest_i;
    nxt_st.force_f = armed;
    if (!armed) begin
      nxt_st.cnt  = '0;
      nxt_st.done = 1'b0;
    end else if (st_ff.cnt == PROP_LAST) begin
      nxt_st.done = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + CNT_W'(1);
    end
    // Disabled monitor never reports a fault
    nxt_st.flag_b = ~(mon_on_i & (st_ff.sync2 | nxt_st.done));
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      st_ff <= '{sync1: 1'b0, sync2: 1'b0, cnt: '0, done: 1'b0,
                 force_f: 1'b0, flag_b: 1'b1};
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end

  assign force_fault_o  = st_ff.force_f;
  assign fault_flag_b_o = st_ff.flag_b;

endmodule

`default_nettype wire

// ### scmc_config_regs_sva.sv
/*
  Checker for the monitor configuration slice: read-back masks, write
  decode, hold, self-test force gating and fault flag delay.
  Assumes it is bound to scmc_config_regs with PROP_CYC handed on.
*/
`timescale 1ns/100ps
`default_nettype none

module scmc_config_regs_sva #(
  parameter int unsigned PROP_CYC = 2
) (
  // Clock and register port
  input wire logic                      clk_sys_i,
  input wire logic                      rst_b_i,
  input wire logic                      ce_i,
  input wire logic [7:0]                reg_addr_i,
  input wire logic [15:0]               reg_wdata_i,
  input wire logic                      reg_wr_i,
  input wire logic                      reg_rd_i,
  input wire logic [15:0]               reg_rdata_o,
  input wire logic                      reg_rvalid_o,
  // Decoded fields and channels
  input wire logic                      io_supply_over_trip_sel_o,
  input wire logic                      io_supply_under_trip_sel_o,
  input wire scmc_pkg::scmc_hot_e       analog_ldo_hot_warn_level_o,
  input wire scmc_pkg::scmc_hot_e       io_ldo_hot_warn_level_o,
  input wire logic                      main_clk_freq_check_on_o,
  input wire logic                      diag_osc_watchdog_on_o,
  input wire logic                      main_clk_watchdog_on_o,
  input wire logic [11:0]               chan_watch_on_o,
  input wire logic [11:0]               chan_force_fault_o,
  input wire logic [11:0]               chan_fault_flag_b_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  // ------------------------------------------------------------
  // Building blocks
  // ------------------------------------------------------------
  sequence s_rd(logic [7:0] a);
    reg_rd_i && ce_i && reg_addr_i == a;
  endsequence
  sequence s_wr(logic [7:0] a);
    reg_wr_i && ce_i && reg_addr_i == a;
  endsequence
  sequence s_forced(int i);
    $rose(chan_force_fault_o[i]);
  endsequence

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_thr_rsvd;
    s_rd(8'h42) |=> reg_rvalid_o && (reg_rdata_o & 16'hCF0F) == 16'h0000;
  endproperty
  a_thr_rsvd: assert property (p_thr_rsvd)
    else $error("threshold reserved bits not zero");

  property p_clk_rsvd;
    s_rd(8'h43) |=> reg_rvalid_o && (reg_rdata_o & 16'h03F8) == 16'h0000;
  endproperty
  a_clk_rsvd: assert property (p_clk_rsvd)
    else $error("clock config reserved bits not zero");

  property p_diag_rsvd;
    s_rd(8'h44) |=> reg_rvalid_o && (reg_rdata_o & 16'h0078) == 16'h0000;
  endproperty
  a_diag_rsvd: assert property (p_diag_rsvd)
    else $error("self-test reserved bits not zero");

  property p_clk_wr;
    s_wr(8'h43) |=> {main_clk_freq_check_on_o, diag_osc_watchdog_on_o,
      main_clk_watchdog_on_o} == $past(reg_wdata_i[2:0]);
  endproperty
  a_clk_wr: assert property (p_clk_wr)
    else $error("clock enables differ from written value");

  property p_trip_wr;
    s_wr(8'h42) |=> {io_supply_over_trip_sel_o,
      io_supply_under_trip_sel_o} == $past(reg_wdata_i[13:12]);
  endproperty
  a_trip_wr: assert property (p_trip_wr)
    else $error("trip selects differ from written value");

  property p_hot_wr;
    s_wr(8'h42) |=> analog_ldo_hot_warn_level_o == $past(reg_wdata_i[7:6])
      && io_ldo_hot_warn_level_o == $past(reg_wdata_i[5:4]);
  endproperty
  a_hot_wr: assert property (p_hot_wr)
    else $error("hot warning levels differ from written value");

  property p_hold;
    !(reg_wr_i && ce_i && reg_addr_i == 8'h43) |=> $stable({
      main_clk_freq_check_on_o, diag_osc_watchdog_on_o,
      main_clk_watchdog_on_o});
  endproperty
  a_hold: assert property (p_hold)
    else $error("clock enables changed without a write");

  property p_force;
    (chan_force_fault_o & ~$past(chan_watch_on_o)) == 12'h000;
  endproperty
  a_force: assert property (p_force)
    else $error("monitor forced while not enabled");

  property p_flag;
    s_forced(11) |-> ##[0:PROP_CYC] !chan_fault_flag_b_o[11];
  endproperty
  a_flag: assert property (p_flag)
    else $error("top channel flag late after self-test");

  property p_flag_gnd;
    s_forced(0) |-> ##[0:PROP_CYC] !chan_fault_flag_b_o[0];
  endproperty
  a_flag_gnd: assert property (p_flag_gnd)
    else $error("ground channel flag late after self-test");
endmodule

bind scmc_config_regs scmc_config_regs_sva #(.PROP_CYC(PROP_CYC)) u_sva (
  .clk_sys_i, .rst_b_i, .ce_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .io_supply_over_trip_sel_o,
  .io_supply_under_trip_sel_o, .analog_ldo_hot_warn_level_o,
  .io_ldo_hot_warn_level_o, .main_clk_freq_check_on_o,
  .diag_osc_watchdog_on_o, .main_clk_watchdog_on_o, .chan_watch_on_o,
  .chan_force_fault_o, .chan_fault_flag_b_o
);

`default_nettype wire

// ### scmc_monitor_model.sv
/*
  Behavioural model of the analog monitors behind the slice.
  Assumes the slice's enables and force lines; raw faults active high.
*/
`timescale 1ns/100ps
`default_nettype none

module scmc_monitor_model (
  // Clock and speed
  input  wire logic        clk_sys_i,
  input  wire logic        slow_i,
  // Slice side
  input  wire logic [11:0] on_i,
  input  wire logic [11:0] force_i,
  output logic      [11:0] raw_o
);
  logic [11:0] d1_ff = 12'h000;
  logic [11:0] d2_ff = 12'h000;
  logic [11:0] d3_ff = 12'h000;

  // Slow comparators trip late, so flags must not rely on a fast answer
  always @(posedge clk_sys_i) begin
    d1_ff <= force_i;
    d2_ff <= d1_ff;
    d3_ff <= d2_ff;
  end

  // Disabled monitors stay quiet
  assign raw_o = on_i & (slow_i ? d3_ff : d1_ff);
endmodule

`default_nettype wire

// ### supply_clock_monitor_config_tb.sv
/*
  Testbench for the monitor configuration slice: defaults, masks, field
  decode, clock enables, self-test force and flags, hold and reset.
  Assumes scmc_pkg, the checker and the monitor model compile first.
*/
`timescale 1ns/100ps
`default_nettype none

module supply_clock_monitor_config_tb;
  logic                clk_sys_i   = 1'b0;
  logic                rst_b_i     = 1'b0;
  logic                ce_i        = 1'b1;
  logic [7:0]          reg_addr_i  = 8'h00;
  logic [15:0]         reg_wdata_i = 16'h0000;
  logic                reg_wr_i    = 1'b0;
  logic                reg_rd_i    = 1'b0;
  logic                slow        = 1'b0;
  logic [15:0]         rdata;
  logic                rvalid, hit, ovr, und, mfc, dow, mwd;
  logic                ahw, ihw, alm, ilm;
  scmc_pkg::scmc_hot_e ahot, ihot;
  logic [11:0]         raw, won, frc, flg;
  int                  fails       = 0;
  int                  n_compared  = 0;

  always #10 clk_sys_i = ~clk_sys_i;

  scmc_config_regs #(.PROP_CYC(2)) uut (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .reg_hit_o(hit),
    .io_supply_over_trip_sel_o(ovr), .io_supply_under_trip_sel_o(und),
    .analog_ldo_hot_warn_level_o(ahot), .io_ldo_hot_warn_level_o(ihot),
    .main_clk_freq_check_on_o(mfc), .diag_osc_watchdog_on_o(dow),
    .main_clk_watchdog_on_o(mwd), .analog_hot_watch_on_o(ahw),
    .io_hot_watch_on_o(ihw), .analog_limit_on_o(alm), .io_limit_on_o(ilm),
    .chan_watch_on_o(won), .chan_raw_fault_i(raw),
    .chan_force_fault_o(frc), .chan_fault_flag_b_o(flg)
  );

  scmc_monitor_model u_mon (
    .clk_sys_i(clk_sys_i), .slow_i(slow), .on_i(won), .force_i(frc),
    .raw_o(raw)
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic test_done();
    if (fails == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  // Extra cycle at the end keeps strobes from being set twice at once
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    cyc(1);
    reg_wr_i = 1'b0;
    cyc(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    cyc(1);
    reg_rd_i = 1'b0;
    chk({15'h0, rvalid}, 16'h0001);
    chk({15'h0, hit}, {15'h0, a inside {[8'h41:8'h44]}});
    chk(rdata, e);
    cyc(1);
  endtask

  // Tight bound on the fall so a slow raw fault cannot mask the self-test
  task automatic wait_flag(input int i, input logic v, input int n);
    for (int k = 0; k < n && flg[i] !== v; k++) cyc(1);
    chk({15'h0, flg[i]}, {15'h0, v});
    if (flg[i] !== v) test_done();
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_defaults();
    rd(8'h41, 16'h0000);
    rd(8'h42, 16'h10F0);
    rd(8'h43, 16'h0000);
    rd(8'h44, 16'h0000);
    rd(8'h40, 16'h0000);
  endtask

  task automatic t_thresh();
    for (int c = 0; c < 4; c++) begin
      wr(8'h42, 16'hCF0F | {2'h0, c[1:0], 4'h0, c[1:0], c[1:0], 4'h0});
      chk({14'h0, ovr, und}, {14'h0, c[1:0]});
      chk({12'h0, ahot, ihot}, {12'h0, c[1:0], c[1:0]});
      rd(8'h42, {2'h0, c[1:0], 4'h0, c[1:0], c[1:0], 4'h0});
    end
  endtask

  task automatic t_clock();
    for (int b = 0; b < 3; b++) begin
      wr(8'h43, 16'h03F8 | (16'h0001 << b));
      chk({13'h0, mfc, dow, mwd}, 16'h0001 << b);
      rd(8'h43, 16'h0001 << b);
    end
    wr(8'h43, 16'h0000);
  endtask

  task automatic t_diag();
    wr(8'h41, 16'h0050);
    chk({12'h0, ahw, ihw, alm, ilm}, 16'h000A);
    chk({4'h0, won}, 16'h0000);
    wr(8'h44, 16'hFFFF);
    rd(8'h44, 16'hFF87);
    cyc(2);
    chk({4'h0, frc}, 16'h0000);
    chk({4'h0, flg}, 16'h0FFF);
    wr(8'h44, 16'h0000);
  endtask

  task automatic t_selftest();
    logic [15:0] m;
    for (int i = 0; i < 12; i++) begin
      m = 16'h0001 << ((i > 2) ? i + 4 : i);
      slow = i[0];
      wr(8'h41, m);
      chk({4'h0, won}, 16'h0001 << i);
      wr(8'h44, m);
      cyc(1);
      chk({4'h0, frc}, 16'h0001 << i);
      wait_flag(i, 1'b0, 1);
      wr(8'h44, 16'h0000);
      wait_flag(i, 1'b1, 20);
      wr(8'h41, 16'h0000);
    end
  endtask

  task automatic t_hold();
    wr(8'h42, 16'h0000);
    ce_i = 1'b0;
    wr(8'h42, 16'h30F0);
    ce_i = 1'b1;
    rd(8'h42, 16'h0000);
    rst_b_i = 1'b0;
    cyc(1);
    rst_b_i = 1'b1;
    rd(8'h42, 16'h10F0);
  endtask

  // ------------------------------------------------------------
  // Main sequence and hang guard
  // ------------------------------------------------------------
  initial begin
    cyc(6);
    rst_b_i = 1'b1;
    t_defaults();
    t_thresh();
    t_clock();
    t_diag();
    t_selftest();
    t_hold();
    test_done();
  end

  initial begin
    #200000;
    fails++;
    test_done();
  end
endmodule

`default_nettype wire
